// ===== core/tcb_pkg.sv
package tcb_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned CNT_W  = 16;

   // register word offsets
   localparam logic [7:0] OFS_POWER_OFF_CONTROL = 8'h00;
   localparam logic [7:0] OFS_TIMER_MODE        = 8'h04;
   localparam logic [7:0] OFS_TIMER_CONTROL     = 8'h08;
   localparam logic [7:0] OFS_TIMER_STATUS      = 8'h0c;
   localparam logic [7:0] OFS_COMPARE_LOW       = 8'h10;
   localparam logic [7:0] OFS_COMPARE_HIGH      = 8'h14;
   localparam logic [7:0] OFS_CAPTURE_LOW       = 8'h18;
   localparam logic [7:0] OFS_CAPTURE_HIGH      = 8'h1c;
   localparam logic [7:0] OFS_SYSTEM_CONTROL    = 8'h20;

   // field positions
   localparam int unsigned POS_CLOCK_ENABLE  = 0;
   localparam int unsigned POS_MODE_LO       = 0;
   localparam int unsigned POS_CLKSEL_LO     = 3;
   localparam int unsigned POS_RUN           = 0;
   localparam int unsigned POS_OVF_ENABLE    = 1;
   localparam int unsigned POS_AUTO_CAPTURE  = 2;
   localparam int unsigned POS_DOUBLE_BUFFER = 3;
   localparam int unsigned POS_OVF_FLAG      = 7;
   localparam int unsigned POS_DIV_SELECT    = 0;
   localparam int unsigned POS_SLOW_MODE     = 1;

   // reset values
   localparam logic [2:0]  RST_MODE    = 3'h0;
   localparam logic [1:0]  RST_CLKSEL  = 2'h0;
   localparam logic [15:0] RST_COMPARE = 16'hffff;
   localparam logic [7:0]  RST_CAPTURE = 8'hff;
   localparam logic [7:0]  RST_TEMP    = 8'hff;

   // timer mode codes
   localparam logic [2:0] MODE_TIMER_A = 3'h0;
   localparam logic [2:0] MODE_TIMER_B = 3'h1;

   // prescaler: exponents of two for select codes 00..11
   localparam int unsigned DIV_W    = 10;
   localparam int unsigned DIV_EXP0 = 10;
   localparam int unsigned DIV_EXP1 = 6;
   localparam int unsigned DIV_EXP2 = 2;
   localparam int unsigned DIV_EXP3 = 1;
   localparam int unsigned LS_DIV_W = 3;
endpackage

// ===== core/tcb_prescaler.sv
`timescale 1ns/1ns
module tcb_prescaler
   import tcb_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       enable,
   input  wire logic [1:0] clk_sel,
   input  wire logic       use_low_speed,
   input  wire logic       low_speed_clock,
   output logic            tick
);
   import tcb_pkg::*;

   logic [DIV_W-1:0]    div_q,  div_d;
   logic [LS_DIV_W-1:0] ls_q,   ls_d;
   logic                sy1_q,  sy2_q, prev_q;
   logic                tick_d;
   logic                ls_edge;

   assign ls_edge = sy2_q & ~prev_q;

   always_comb begin
      div_d  = enable ? div_q + 1'b1 : '0;
      ls_d   = ls_q;
      tick_d = 1'b0;
      if (enable && ls_edge) begin
         ls_d = ls_q + 1'b1;
      end
      if (!enable) begin
         ls_d = '0;
      end else if (clk_sel == 2'h0 && use_low_speed) begin
         tick_d = ls_edge && (&ls_q);
      end else begin
         case (clk_sel)
            2'h0:    tick_d = &div_q[DIV_EXP0-1:0];
            2'h1:    tick_d = &div_q[DIV_EXP1-1:0];
            2'h2:    tick_d = &div_q[DIV_EXP2-1:0];
            default: tick_d = &div_q[DIV_EXP3-1:0];
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q  <= '0;
         ls_q   <= '0;
         sy1_q  <= 1'b0;
         sy2_q  <= 1'b0;
         prev_q <= 1'b0;
         tick   <= 1'b0;
      end else begin
         div_q  <= div_d;
         ls_q   <= ls_d;
         sy1_q  <= low_speed_clock;
         sy2_q  <= sy1_q;
         prev_q <= sy2_q;
         tick   <= tick_d;
      end
   end
endmodule

// ===== core/tcb_timer.sv
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ns
// How it works
// - clock enable bit gates whole timer
// - clock enable resets to zero
// - mode 000 or 001 is timer mode
// - run starts; mode/overflow-enable writes ignored running
// - select divides by 1024,64,4,2 or slow/8
// - sixteen-bit counter counts selected ticks
// - match raises request, clears counter, continues
// - clearing run stops and zeroes counter
// - capture low read latches high byte
// - capture works stopped; low reads zero
// - high byte kept; cleared on stopped read
// - capture active immediately after start
// - stopping write leaves auto-capture unchanged
// - compare low goes to holding latch
// - double buffer bit enables buffering
// - running buffered value loads at match
// - buffered reads return latest written value
// - stopped write loads buffer and active
// - unbuffered write takes effect immediately
// - overflow flag; status read clears; writes ignored
// - stop state entry clears run bit
module tcb_timer
   import tcb_pkg::*;
(
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [tcb_pkg::ADDR_W-1:0] paddr,
   input  wire logic [tcb_pkg::DATA_W-1:0] pwdata,
   output logic      [tcb_pkg::DATA_W-1:0] prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      low_speed_clock,
   input  wire logic                      stop_enter,
   output logic                           timer_match_interrupt
);
   import tcb_pkg::*;

   // control state
   logic             clk_en_q,   clk_en_d;
   logic [2:0]       mode_q,     mode_d;
   logic [1:0]       clksel_q,   clksel_d;
   logic             run_q,      run_d;
   logic             ovf_en_q,   ovf_en_d;
   logic             acap_q,     acap_d;
   logic             dbf_q,      dbf_d;
   logic             div_sel_q,  div_sel_d;
   logic             slow_q,     slow_d;
   logic             ovf_flag_q, ovf_flag_d;

   // counting and data state
   logic [CNT_W-1:0] cnt_q,      cnt_d;
   logic [CNT_W-1:0] cmp_act_q,  cmp_act_d;
   logic [CNT_W-1:0] cmp_buf_q,  cmp_buf_d;
   logic [7:0]       temp_q,     temp_d;
   logic [7:0]       cap_lo_q,   cap_lo_d;
   logic [7:0]       cap_hi_q,   cap_hi_d;
   logic             irq_d;

   // bus state
   logic [DATA_W-1:0] prdata_d;
   logic              pready_d;
   logic              pslverr_d;

   logic             tick;
   logic             timer_mode;
   logic             counting;
   logic             first_ph;
   logic             wr_fire;
   logic             rd_first;
   logic             mapped;
   logic [CNT_W-1:0] commit_val;
   logic [7:0]       rd_byte;
   logic             match_hit;
   logic             stat_rd;
   logic             cap_rd;

   assign timer_mode = (mode_q == MODE_TIMER_A) || (mode_q == MODE_TIMER_B);
   // gated clock or stopped: no compare and no request
   assign counting   = clk_en_q && run_q && timer_mode;
   assign first_ph   = psel && penable && !pready;
   assign wr_fire    = psel && penable && pready && pwrite;
   assign rd_first   = first_ph && !pwrite && clk_en_q;
   assign commit_val = {pwdata[7:0], temp_q};
   // read side effects act in the first access cycle, with the sampled data
   assign stat_rd    = rd_first && (paddr == OFS_TIMER_STATUS);
   assign cap_rd     = rd_first && (paddr == OFS_CAPTURE_LOW) && acap_q;
   assign match_hit  = cnt_q == cmp_act_q;

   always_comb begin
      case (paddr)
         OFS_POWER_OFF_CONTROL,
         OFS_TIMER_MODE,
         OFS_TIMER_CONTROL,
         OFS_TIMER_STATUS,
         OFS_COMPARE_LOW,
         OFS_COMPARE_HIGH,
         OFS_CAPTURE_LOW,
         OFS_CAPTURE_HIGH,
         OFS_SYSTEM_CONTROL: mapped = 1'b1;
         default:            mapped = 1'b0;
      endcase
   end

   tcb_prescaler u_prescaler (
      .pclk            (pclk),
      .presetn         (presetn),
      .enable          (counting),
      .clk_sel         (clksel_q),
      .use_low_speed   (div_sel_q || slow_q),
      .low_speed_clock (low_speed_clock),
      .tick            (tick)
   );

   // read data: timer registers read zero while gated
   always_comb begin
      rd_byte = 8'h00;
      case (paddr)
         OFS_POWER_OFF_CONTROL: begin
            rd_byte[POS_CLOCK_ENABLE] = clk_en_q;
         end
         OFS_SYSTEM_CONTROL: begin
            rd_byte[POS_DIV_SELECT] = div_sel_q;
            rd_byte[POS_SLOW_MODE]  = slow_q;
         end
         OFS_TIMER_MODE: begin
            rd_byte[POS_MODE_LO+:3]   = mode_q;
            rd_byte[POS_CLKSEL_LO+:2] = clksel_q;
         end
         OFS_TIMER_CONTROL: begin
            rd_byte[POS_RUN]           = run_q;
            rd_byte[POS_OVF_ENABLE]    = ovf_en_q;
            rd_byte[POS_AUTO_CAPTURE]  = acap_q;
            rd_byte[POS_DOUBLE_BUFFER] = dbf_q;
         end
         OFS_TIMER_STATUS: begin
            rd_byte[POS_OVF_FLAG] = ovf_flag_q;
         end
         OFS_COMPARE_LOW: begin
            rd_byte = dbf_q ? cmp_buf_q[7:0] : cmp_act_q[7:0];
         end
         OFS_COMPARE_HIGH: begin
            rd_byte = dbf_q ? cmp_buf_q[15:8] : cmp_act_q[15:8];
         end
         OFS_CAPTURE_LOW: begin
            if (acap_q) begin
               rd_byte = run_q ? cnt_q[7:0] : 8'h00;
            end else begin
               rd_byte = cap_lo_q;
            end
         end
         OFS_CAPTURE_HIGH: begin
            rd_byte = cap_hi_q;
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
      if (!clk_en_q && paddr != OFS_POWER_OFF_CONTROL) begin
         rd_byte = 8'h00;
      end
   end

   // bus answer: one wait cycle, then pready for one cycle
   always_comb begin
      pready_d  = first_ph;
      pslverr_d = first_ph && !mapped;
      prdata_d  = '0;
      if (first_ph && !pwrite) begin
         prdata_d = {{(DATA_W-8){1'b0}}, rd_byte};
      end
   end

   // writes while gated are dropped, except the clock enable and system control
   // control registers
   always_comb begin
      clk_en_d  = clk_en_q;
      mode_d    = mode_q;
      clksel_d  = clksel_q;
      run_d     = run_q;
      ovf_en_d  = ovf_en_q;
      acap_d    = acap_q;
      dbf_d     = dbf_q;
      div_sel_d = div_sel_q;
      slow_d    = slow_q;
      if (wr_fire) begin
         case (paddr)
            OFS_POWER_OFF_CONTROL: begin
               clk_en_d = pwdata[POS_CLOCK_ENABLE];
            end
            OFS_SYSTEM_CONTROL: begin
               div_sel_d = pwdata[POS_DIV_SELECT];
               slow_d    = pwdata[POS_SLOW_MODE];
            end
            OFS_TIMER_MODE: begin
               if (clk_en_q && !run_q) begin
                  mode_d   = pwdata[POS_MODE_LO+:3];
                  clksel_d = pwdata[POS_CLKSEL_LO+:2];
               end
            end
            OFS_TIMER_CONTROL: begin
               if (clk_en_q) begin
                  run_d = pwdata[POS_RUN];
                  dbf_d = pwdata[POS_DOUBLE_BUFFER];
                  if (!run_q) begin
                     ovf_en_d = pwdata[POS_OVF_ENABLE];
                  end
                  if (!(run_q && !pwdata[POS_RUN])) begin
                     acap_d = pwdata[POS_AUTO_CAPTURE];
                  end
               end
            end
            default: begin
            end
         endcase
      end
      if (stop_enter) begin
         run_d = 1'b0;
      end
   end

   // counter, compare and capture
   always_comb begin
      cnt_d      = cnt_q;
      cmp_act_d  = cmp_act_q;
      cmp_buf_d  = cmp_buf_q;
      temp_d     = temp_q;
      cap_lo_d   = cap_lo_q;
      cap_hi_d   = cap_hi_q;
      ovf_flag_d = ovf_flag_q;
      irq_d      = 1'b0;
      if (stat_rd) begin
         ovf_flag_d = 1'b0;
      end
      if (cap_rd) begin
         cap_hi_d = run_q ? cnt_q[15:8] : 8'h00;
      end
      // not counting: counter and prescaler held at zero
      if (!counting) begin
         cnt_d = '0;
      end else if (tick) begin
         // with double buffering, a commit in the match cycle lands in the buffer only
         if (match_hit) begin
            irq_d     = 1'b1;
            cnt_d     = '0;
            cmp_act_d = dbf_q ? cmp_buf_q : cmp_act_q;
         end else begin
            cnt_d = cnt_q + 1'b1;
            // set wins over a status-read clear in the same cycle
            if (&cnt_q && ovf_en_q) begin
               ovf_flag_d = 1'b1;
            end
         end
      end
      if (wr_fire && clk_en_q) begin
         case (paddr)
            OFS_COMPARE_LOW: begin
               temp_d = pwdata[7:0];
            end
            OFS_COMPARE_HIGH: begin
               cmp_buf_d = commit_val;
               if (!(dbf_q && run_q)) begin
                  cmp_act_d = commit_val;
               end
            end
            OFS_CAPTURE_LOW: begin
               cap_lo_d = pwdata[7:0];
            end
            OFS_CAPTURE_HIGH: begin
               cap_hi_d = pwdata[7:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_en_q  <= 1'b0;
         mode_q    <= RST_MODE;
         clksel_q  <= RST_CLKSEL;
         run_q     <= 1'b0;
         ovf_en_q  <= 1'b0;
         acap_q    <= 1'b0;
         dbf_q     <= 1'b0;
         div_sel_q <= 1'b0;
         slow_q    <= 1'b0;
      end else begin
         clk_en_q  <= clk_en_d;
         mode_q    <= mode_d;
         clksel_q  <= clksel_d;
         run_q     <= run_d;
         ovf_en_q  <= ovf_en_d;
         acap_q    <= acap_d;
         dbf_q     <= dbf_d;
         div_sel_q <= div_sel_d;
         slow_q    <= slow_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q      <= '0;
         cmp_act_q  <= RST_COMPARE;
         cmp_buf_q  <= RST_COMPARE;
         temp_q     <= RST_TEMP;
         cap_lo_q   <= RST_CAPTURE;
         cap_hi_q   <= RST_CAPTURE;
         ovf_flag_q <= 1'b0;
         timer_match_interrupt <= 1'b0;
      end else begin
         cnt_q      <= cnt_d;
         cmp_act_q  <= cmp_act_d;
         cmp_buf_q  <= cmp_buf_d;
         temp_q     <= temp_d;
         cap_lo_q   <= cap_lo_d;
         cap_hi_q   <= cap_hi_d;
         ovf_flag_q <= ovf_flag_d;
         timer_match_interrupt <= irq_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= prdata_d;
         pready  <= pready_d;
         pslverr <= pslverr_d;
      end
   end
endmodule

// ===== dv/tcb_timer_chk.sv
`timescale 1ns/1ns
module tcb_timer_chk
   import tcb_pkg::*;
(
   input wire logic                        pclk,
   input wire logic                        presetn,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [tcb_pkg::ADDR_W-1:0]  paddr,
   input wire logic [tcb_pkg::DATA_W-1:0]  pwdata,
   input wire logic [tcb_pkg::DATA_W-1:0]  prdata,
   input wire logic                        pready,
   input wire logic                        pslverr,
   input wire logic                        low_speed_clock,
   input wire logic                        stop_enter,
   input wire logic                        timer_match_interrupt
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ans_one_a: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered after one wait state");
   ans_pulse_a: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   idle_data_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside ready cycle");
   wide_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read data bits not zero");
   err_pair_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   map_err_a: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > OFS_SYSTEM_CONTROL))
      else $error("error flag disagrees with address map");
   stat_bits_a: assert property (pready && !pwrite && paddr == OFS_TIMER_STATUS |-> prdata[6:0] == 7'h0)
      else $error("status unused bits not zero");
   irq_pulse_a: assert property (timer_match_interrupt |=> !timer_match_interrupt)
      else $error("match request longer than one cycle");
   stop_quiet_a: assert property (stop_enter [*3] |-> !timer_match_interrupt)
      else $error("match request while stopped");

   cover property (timer_match_interrupt);
   cover property (pslverr);
   cover property (stop_enter [*3]);
endmodule

bind tcb_timer tcb_timer_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .low_speed_clock, .stop_enter, .timer_match_interrupt);

// ===== dv/tcb_timer_test.sv
`timescale 1ns/1ns
module tcb_timer_test;
   import tcb_pkg::*;
   logic               pclk, presetn, psel, penable, pwrite, low_speed_clock, stop_enter;
   logic [ADDR_W-1:0]  paddr;
   logic [DATA_W-1:0]  pwdata, prdata, rd;
   logic               pready, pslverr, timer_match_interrupt;
   logic [7:0]         cmp;
   int                 n_mismatch, check_count, c, seed;
   int                 m_temp, m_buf, m_act;
   bit                 m_hold;
   int                 ex [4] = '{10, 6, 2, 1};

   tcb_timer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .low_speed_clock, .stop_enter, .timer_match_interrupt);

   always #50 pclk = ~pclk;
   always #500 low_speed_clock = ~low_speed_clock;

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      if (n >= 20) chk("pready", 1, 0);
      chk("pslverr", 32'(a > OFS_SYSTEM_CONTROL), 32'(pslverr));
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask

   task cmpw(input logic [7:0] v);
      apb(1'b1, OFS_COMPARE_LOW, {24'h0, v});
      apb(1'b1, OFS_COMPARE_HIGH, 32'h0);
      m_temp = v;
      m_buf = m_temp;
      if (!m_hold) begin
         m_act = m_buf;
      end
   endtask

   task wirq;
      c = 0;
      do begin
         @(posedge pclk);
         c++;
      end while (timer_match_interrupt !== 1'b1 && c < 5000);
      if (c >= 5000) chk("irq wait", 1, 0);
   endtask

   task per(input int e);
      wirq();
      wirq();
      chk("period", e, c);
   endtask

   task print_verdict;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge pclk);
      n_mismatch++;
      print_verdict();
   end

   initial begin
      seed = 32'h3e32b89d;
      m_temp = RST_TEMP;
      m_buf = RST_COMPARE;
      m_act = RST_COMPARE;
      m_hold = 1'b0;
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      low_speed_clock = 1'b0;
      stop_enter = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, OFS_TIMER_MODE, 32'h18);
      rdc(OFS_POWER_OFF_CONTROL, 0, "clock enable");
      apb(1'b1, OFS_POWER_OFF_CONTROL, 32'h1);
      rdc(OFS_TIMER_MODE, 0, "gated mode write");
      rdc(OFS_TIMER_CONTROL, 0, "control reset");
      rdc(OFS_COMPARE_HIGH, 32'hff, "compare reset");
      rdc(8'h24, 0, "unmapped");
      $display("test reset done");
      cmpw(8'h1);
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, OFS_TIMER_MODE, 32'(s * 8 + s % 2));
         apb(1'b1, OFS_TIMER_CONTROL, 32'h1);
         per(2 << ex[s]);
         apb(1'b1, OFS_TIMER_MODE, 32'h7);
         rdc(OFS_TIMER_MODE, 32'(s * 8 + s % 2), "mode locked");
         apb(1'b1, OFS_TIMER_CONTROL, 32'h0);
      end
      $display("test selects done");
      cmp = 8'(3 + $unsigned($random(seed)) % 8);
      cmpw(cmp);
      rdc(OFS_COMPARE_LOW, {24'h0, cmp}, "compare low");
      apb(1'b1, OFS_TIMER_CONTROL, 32'h5);
      apb(1'b0, OFS_CAPTURE_LOW, 32'h0);
      chk("capture live", 1, 32'(rd <= cmp));
      rdc(OFS_CAPTURE_HIGH, 0, "capture high");
      per(2 * (m_act + 1));
      apb(1'b1, OFS_TIMER_CONTROL, 32'h0);
      rdc(OFS_TIMER_CONTROL, 32'h4, "capture kept");
      apb(1'b1, OFS_CAPTURE_HIGH, 32'h5a);
      rdc(OFS_CAPTURE_HIGH, 32'h5a, "capture high kept");
      rdc(OFS_CAPTURE_LOW, 0, "stopped capture low");
      rdc(OFS_CAPTURE_HIGH, 0, "stopped capture high");
      $display("test capture done");
      apb(1'b1, OFS_TIMER_CONTROL, 32'h8);
      cmpw(8'h3);
      apb(1'b1, OFS_TIMER_CONTROL, 32'h9);
      per(8);
      m_hold = 1'b1;
      cmpw(8'h7);
      wirq();
      chk("buffered hold", 1, 32'(c <= 2 * (m_act + 1)));
      m_act = m_buf;
      rdc(OFS_COMPARE_LOW, m_buf, "buffered read");
      per(2 * (m_buf + 1));
      m_hold = 1'b0;
      stop_enter <= 1'b1;
      repeat (4) @(posedge pclk);
      stop_enter <= 1'b0;
      rdc(OFS_TIMER_CONTROL, 32'h8, "stop state");
      apb(1'b1, OFS_TIMER_STATUS, 32'hff);
      rdc(OFS_TIMER_STATUS, 0, "status");
      $display("test buffer done");
      apb(1'b1, OFS_TIMER_CONTROL, 32'h0);
      apb(1'b1, OFS_SYSTEM_CONTROL, 32'h1);
      apb(1'b1, OFS_TIMER_MODE, 32'h0);
      cmpw(8'h1);
      apb(1'b1, OFS_TIMER_CONTROL, 32'h1);
      per(160);
      $display("test low speed done");
      apb(1'b1, OFS_TIMER_CONTROL, 32'h0);
      apb(1'b1, OFS_POWER_OFF_CONTROL, 32'h0);
      apb(1'b1, OFS_TIMER_CONTROL, 32'h1);
      c = 0;
      repeat (400) begin
         @(posedge pclk);
         if (timer_match_interrupt === 1'b1) begin
            c++;
         end
      end
      chk("gated irq", 0, c);
      rdc(OFS_TIMER_CONTROL, 0, "gated control");
      $display("test gate done");
      print_verdict();
   end
endmodule
